/* include/lsm_defines.svh */
// Timing constants for the line-sync mode and status block.
// Assumes a 40 MHz core clock; counts are derived from printed times.
`ifndef LSM_DEFINES_SVH
`define LSM_DEFINES_SVH
`define LSM_CLK_HZ          40000000
`define LSM_LAMP_RED_MS     100
`define LSM_LAMP_RED_CYC    ((`LSM_CLK_HZ / 1000) * `LSM_LAMP_RED_MS)
`define LSM_MASTER_RATE_HZ  23191
`define LSM_MASTER_LINE_CYC (`LSM_CLK_HZ / `LSM_MASTER_RATE_HZ)
`define LSM_MIN_TRIG_HZ     300
`define LSM_TRIG_TMO_CYC    (`LSM_CLK_HZ / `LSM_MIN_TRIG_HZ)
`define LSM_TRIG_HIGH_NS    100
`define LSM_TRIG_HIGH_CYC   ((`LSM_TRIG_HIGH_NS * 40 + 999) / 1000)
`define LSM_LINE_VALID_OUT_LOW_CYC    32
`define LSM_CNT_W           24
`endif

/* include/lsm_pkg.sv */
// Types shared by the line-sync mode and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package lsm_pkg;
  typedef enum logic [1:0] {
    LSM_ST_POWERUP = 2'b00,
    LSM_ST_MASTER  = 2'b01,
    LSM_ST_SLAVE   = 2'b10,
    LSM_ST_FAULT   = 2'b11
  } lsm_mode_t;
  typedef enum logic [1:0] {
    LSM_LAMP_OFF   = 2'b00,
    LSM_LAMP_RED   = 2'b01,
    LSM_LAMP_GREEN = 2'b10
  } lsm_lamp_t;
endpackage : lsm_pkg

/* logic/lsm_line_gen.sv */
// Line-valid pulse generator: free-running or restarted by a trigger edge.
// Assumes start_i is a synchronous one-cycle pulse on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module lsm_line_gen #(
  parameter int CNT_W    = 24,
  parameter int PERIOD   = 1724,
  parameter int LOW_CYC  = 32
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Control
  input  wire logic run_i,
  input  wire logic free_i,
  input  wire logic start_i,
  // Line output
  output logic      line_start_o,
  output logic      line_valid_o
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);
  localparam logic [CNT_W-1:0] HIGH = CNT_W'(PERIOD - LOW_CYC);
  logic [CNT_W-1:0] cnt_reg;
  logic             busy_reg;

  // Free mode wraps at the period; triggered mode holds after one line
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !run_i) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (start_i || (free_i && (cnt_reg == LAST || !busy_reg))) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b1;
    end else if (busy_reg && cnt_reg != LAST) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (!free_i) begin
      busy_reg <= 1'b0;
    end
  end

  // Registered outputs; line valid high while inside the active part
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      line_start_o <= 1'b0;
      line_valid_o <= 1'b0;
    end else begin
      line_start_o <= run_i && (start_i || (free_i && (cnt_reg == LAST || !busy_reg)));
      line_valid_o <= busy_reg && (cnt_reg < HIGH) && !start_i;
    end
  end
endmodule : lsm_line_gen
`default_nettype wire

/* logic/lsm_line_sync.sv */
// Line-sync mode selection and bi-colour status lamp of a line-scan camera.
// Assumes an asynchronous trigger pin, init result from the sensor setup logic.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defines.svh"
module lsm_line_sync
  import lsm_pkg::*;
#(
  parameter int CNT_W      = `LSM_CNT_W,
  parameter int RED_CYC    = `LSM_LAMP_RED_CYC,
  parameter int TMO_CYC    = `LSM_TRIG_TMO_CYC,
  parameter int LINE_CYC   = `LSM_MASTER_LINE_CYC
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Power-up init result (same clock domain)
  input  wire logic init_done_i,
  input  wire logic init_ok_i,
  // External line trigger pin
  input  wire logic line_trigger_in,
  // Line timing
  output logic      line_valid_out,
  output logic      line_start_o,
  // Status
  output logic      lamp_red_o,
  output logic      lamp_green_o,
  output logic      slave_mode_o
);
  localparam logic [CNT_W-1:0] RED_LAST = CNT_W'(RED_CYC - 1);
  localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TMO_CYC - 1);
  localparam logic [CNT_W-1:0] LINE_LAST = CNT_W'(LINE_CYC - 1);

  lsm_mode_t        mode_reg;
  lsm_lamp_t        lamp_next;
  logic [CNT_W-1:0] pwr_cnt_reg;
  logic [CNT_W-1:0] tmo_cnt_reg;
  logic             trig_meta_reg;
  logic             trig_sync_reg;
  logic             trig_prev_reg;
  logic             trig_rise;
  logic             lost_reg;
  logic             red_done;
  logic [CNT_W-1:0] since_start_reg;
  logic             start_in_master_reg;

  // Two-stage synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_meta_reg <= line_trigger_in;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  assign trig_rise = trig_sync_reg && !trig_prev_reg;
  assign red_done  = (pwr_cnt_reg == RED_LAST);

  // Power-up red interval counter, saturates at its end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pwr_cnt_reg <= '0;
    end else if (!red_done) begin
      pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
    end
  end

  // Mode machine; slave is absorbing so only srst_i leaves it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode_reg <= LSM_ST_POWERUP;
    end else begin
      case (mode_reg)
        LSM_ST_POWERUP: begin
          if (red_done && init_done_i) begin
            mode_reg <= init_ok_i ? LSM_ST_MASTER : LSM_ST_FAULT;
          end
        end
        LSM_ST_MASTER: begin
          if (trig_rise) begin
            mode_reg <= LSM_ST_SLAVE;
          end
        end
        LSM_ST_SLAVE:  mode_reg <= LSM_ST_SLAVE;
        LSM_ST_FAULT:  mode_reg <= LSM_ST_FAULT;
        default:       mode_reg <= LSM_ST_POWERUP;
      endcase
    end
  end

  // Trigger watchdog; a fresh edge wins over the timeout in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i || mode_reg != LSM_ST_SLAVE || trig_rise) begin
      tmo_cnt_reg <= '0;
      lost_reg    <= 1'b0;
    end else if (tmo_cnt_reg == TMO_LAST) begin
      lost_reg <= 1'b1;
    end else begin
      tmo_cnt_reg <= tmo_cnt_reg + 1'b1;
    end
  end

  // Lamp colour from mode and trigger health
  always_comb begin
    lamp_next = LSM_LAMP_RED;
    case (mode_reg)
      LSM_ST_POWERUP: lamp_next = LSM_LAMP_RED;
      LSM_ST_MASTER:  lamp_next = LSM_LAMP_GREEN;
      LSM_ST_SLAVE:   lamp_next = lost_reg ? LSM_LAMP_RED : LSM_LAMP_GREEN;
      LSM_ST_FAULT:   lamp_next = LSM_LAMP_RED;
      default:        lamp_next = LSM_LAMP_RED;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lamp_red_o   <= 1'b1;
      lamp_green_o <= 1'b0;
      slave_mode_o <= 1'b0;
    end else begin
      lamp_red_o   <= (lamp_next == LSM_LAMP_RED);
      lamp_green_o <= (lamp_next == LSM_LAMP_GREEN);
      slave_mode_o <= (mode_reg == LSM_ST_SLAVE);
    end
  end

  // Line generator: free-running in master, restarted per edge in slave
  lsm_line_gen #(
    .CNT_W   (CNT_W),
    .PERIOD  (LINE_CYC),
    .LOW_CYC (`LSM_LINE_VALID_OUT_LOW_CYC)
  ) u_line_gen (
    .core_clk_i   (core_clk_i),
    .srst_i       (srst_i),
    .run_i        (mode_reg == LSM_ST_MASTER || mode_reg == LSM_ST_SLAVE),
    .free_i       (mode_reg == LSM_ST_MASTER),
    .start_i      (mode_reg == LSM_ST_SLAVE && trig_rise),
    .line_start_o (line_start_o),
    .line_valid_o (line_valid_out)
  );

  // Cycles since the last line start; only the period assertion reads it.
  // The first start after entering master has no predecessor, so it is marked.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      since_start_reg     <= '0;
      start_in_master_reg <= 1'b0;
    end else if (line_start_o) begin
      since_start_reg     <= '0;
      start_in_master_reg <= (mode_reg == LSM_ST_MASTER);
    end else if (since_start_reg != '1) begin
      since_start_reg <= since_start_reg + 1'b1;
    end
  end

  // Assertions
  a_slave_sticky: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_SLAVE) |=> (mode_reg == LSM_ST_SLAVE))
    else $error("slave mode left");
  a_fault_no_green: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_FAULT) |=> !lamp_green_o)
    else $error("green in fault");
  a_powerup_red: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_POWERUP) |=> lamp_red_o && !lamp_green_o)
    else $error("not red at power-up");
  a_red_min_time: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg != LSM_ST_POWERUP) |-> red_done)
    else $error("red interval cut short");
  a_master_switch: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_MASTER && trig_rise) |=> (mode_reg == LSM_ST_SLAVE))
    else $error("trigger did not enter slave");
  a_master_green: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_MASTER) |=> lamp_green_o)
    else $error("master lamp not green");
  a_slave_line_start: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_SLAVE && trig_rise) |=> line_start_o)
    else $error("edge did not start line");
  a_loss_red: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (lost_reg && mode_reg == LSM_ST_SLAVE) |=> lamp_red_o)
    else $error("loss not shown red");
  a_resume_green: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_SLAVE && trig_rise) |=> ##1 lamp_green_o)
    else $error("green not restored");
  a_loss_bound: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (tmo_cnt_reg == TMO_LAST && mode_reg == LSM_ST_SLAVE && !trig_rise) |=> lost_reg)
    else $error("timeout not flagged");
  a_master_rate: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (mode_reg == LSM_ST_MASTER && start_in_master_reg && line_start_o) |->
      (since_start_reg == LINE_LAST))
    else $error("master line period wrong");

  c_enter_master: cover property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(mode_reg == LSM_ST_MASTER));
  c_enter_slave: cover property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(mode_reg == LSM_ST_SLAVE));
  c_trig_lost: cover property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(lost_reg));
  c_fault: cover property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(mode_reg == LSM_ST_FAULT));
endmodule : lsm_line_sync
`default_nettype wire

/* bench/lsm_trig_src.sv */
// Trigger source model standing in for the frame grabber or encoder.
// Assumes the bench changes run_i at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module lsm_trig_src #(
  parameter int HIGH_CYC = 6 // 150 ns, above the minimum high time
) (
  // Clock and control
  input  wire logic       core_clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] period_i,
  // Trigger pin
  output logic            line_trigger_o
);
  logic [7:0] cnt_reg = 8'h00;
  initial line_trigger_o = 1'b0;
  // One pulse per period; acts on the rising edge so run_i, changed at the
  // falling edge, is never raced. A stopped source finishes its pulse, so no
  // runt pulse below the minimum high time, then idles low like a dropped cable
  always @(posedge core_clk_i) begin
    if (run_i || cnt_reg != 8'h00) begin
      cnt_reg <= (cnt_reg + 8'h01 >= period_i) ? 8'h00 : cnt_reg + 8'h01;
    end
    line_trigger_o <= (run_i || cnt_reg != 8'h00) && (cnt_reg < HIGH_CYC);
  end
endmodule : lsm_trig_src
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the line-sync mode and status block.
// Assumes shortened red, timeout and line counts set below.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defines.svh"
module tb_top;
  localparam int RED  = 100;
  localparam int TMO  = 200;
  localparam int LINE = 40;
  localparam int TPER = 30;
  logic core_clk_i  = 1'b0;
  logic srst_i      = 1'b1;
  logic init_done_i = 1'b1;
  logic init_ok_i   = 1'b1;
  logic trig_run    = 1'b0;
  logic line_trigger_in, line_valid_out, line_start_o;
  logic lamp_red_o, lamp_green_o, slave_mode_o;
  int   fail_count  = 0;
  int   num_checks  = 0;
  int   cyc         = 0;
  int   n;

  // 40 MHz clock
  always #12.5 core_clk_i = ~core_clk_i;

  lsm_line_sync #(.RED_CYC(RED), .TMO_CYC(TMO), .LINE_CYC(LINE)) lsm_line_sync_i (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .init_done_i(init_done_i),
    .init_ok_i(init_ok_i), .line_trigger_in(line_trigger_in),
    .line_valid_out(line_valid_out), .line_start_o(line_start_o),
    .lamp_red_o(lamp_red_o), .lamp_green_o(lamp_green_o), .slave_mode_o(slave_mode_o));

  lsm_trig_src lsm_trig_src_i (
    .core_clk_i(core_clk_i), .run_i(trig_run), .period_i(8'h1E),
    .line_trigger_o(line_trigger_in));

  task automatic chk(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic cycles(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask : cycles

  // Hold reset for 8 cycles with the chosen init result
  task automatic do_reset(input logic ok);
    srst_i    = 1'b1;
    init_ok_i = ok;
    trig_run  = 1'b0;
    cycles(8);
    srst_i    = 1'b0;
  endtask : do_reset

  // Cycles between two line starts, bounded so a dead output cannot hang
  task automatic gap(output int g);
    g = 0;
    while (line_start_o !== 1'b1 && g < 500) begin
      cycles(1);
      g++;
    end
    g = 0;
    do begin
      cycles(1);
      g++;
    end while (line_start_o !== 1'b1 && g < 500);
  endtask : gap

  task automatic t_powerup;
    do_reset(1'b1);
    cycles(RED / 2);
    chk(lamp_red_o, 1'b1, "lamp not red early");
    chk(lamp_green_o, 1'b0, "green too early");
    cycles(RED / 2 + 6);
    chk(lamp_green_o, 1'b1, "no green after init");
    chk(lamp_red_o, 1'b0, "red after init");
    chk(slave_mode_o, 1'b0, "not master");
    gap(n);
    chk(n == LINE, 1'b1, "master line period");
    // Line valid follows the start by one cycle, high for the active part
    chk(line_valid_out, 1'b0, "line valid before start");
    cycles(1);
    chk(line_valid_out, 1'b1, "line valid not raised");
    cycles(LINE - `LSM_LINE_VALID_OUT_LOW_CYC - 1);
    chk(line_valid_out, 1'b1, "line valid ended early");
    cycles(1);
    chk(line_valid_out, 1'b0, "line valid ended late");
    $display("test powerup and master done");
  endtask : t_powerup

  task automatic t_slave;
    trig_run = 1'b1;
    cycles(3 * TPER);
    chk(slave_mode_o, 1'b1, "no slave mode");
    chk(lamp_green_o, 1'b1, "lamp left green");
    gap(n);
    chk(n == TPER, 1'b1, "slave line period");
    $display("test slave done");
  endtask : t_slave

  task automatic t_loss;
    trig_run = 1'b0;
    cycles(TMO + TPER + 10);
    chk(lamp_red_o, 1'b1, "loss not flagged");
    chk(slave_mode_o, 1'b1, "fell back to master");
    trig_run = 1'b1;
    cycles(2 * TPER);
    chk(lamp_green_o, 1'b1, "green not restored");
    chk(slave_mode_o, 1'b1, "slave lost on resume");
    $display("test trigger loss done");
  endtask : t_loss

  // Init result arrives late and fails; red must hold throughout
  task automatic t_fault;
    init_done_i = 1'b0;
    do_reset(1'b0);
    cycles(RED + 10);
    chk(lamp_red_o, 1'b1, "not red while init pending");
    chk(lamp_green_o, 1'b0, "green before init done");
    init_done_i = 1'b1;
    cycles(40);
    chk(lamp_green_o, 1'b0, "green on failed init");
    chk(lamp_red_o, 1'b1, "fault not red");
    trig_run = 1'b1;
    cycles(3 * TPER);
    chk(slave_mode_o, 1'b0, "trigger taken in fault");
    $display("test init fault done");
  endtask : t_fault

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Cycle ceiling well above the roughly 900 cycles the tests need
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    t_powerup();
    t_slave();
    t_loss();
    t_fault();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
